// ---- rtc_pkg.sv ----
// Package for the readout timing configuration block
package rtc_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] STROBE_LENGTH_CONTROL_ADDR = 8'h56;
    localparam logic [7:0] ADDRESS_CODING_DIRECTION_ADDR = 8'h57;
    localparam logic [7:0] SAMPLE_PULSE_WIDTH_ADDR = 8'h5f;
    localparam logic [7:0] RESET_PULSE_WIDTH_ADDR = 8'h60;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [3:0] STROBE_LENGTH_RST = 4'he;
    localparam logic [3:0] ADDRESS_CODING_RST = 4'h4;
    localparam logic [5:0] SAMPLE_PULSE_RST = 6'h0a;
    localparam logic [5:0] RESET_PULSE_RST = 6'h0a;

    // ------------------------------------------------------------
    // Field positions and strobe width codes
    // ------------------------------------------------------------
    localparam int ROW_VALID_LSB = 0;
    localparam int SOF_LSB = 2;
    localparam int COL_REV_BIT = 0;
    localparam int ROW_REV_BIT = 1;
    localparam int COL_GRAY_BIT = 2;
    localparam int ROW_GRAY_BIT = 3;
    localparam logic [1:0] WIDTH_CODE_1 = 2'h0;
    localparam logic [1:0] WIDTH_CODE_8 = 2'h1;
    localparam logic [1:0] WIDTH_CODE_64 = 2'h2;
    localparam logic [1:0] WIDTH_CODE_ROW = 2'h3;

    // ------------------------------------------------------------
    // Timing counts in master clocks; zero length means full row
    // ------------------------------------------------------------
    localparam logic [6:0] LEN_FULL_ROW = 7'h00;
    localparam logic [6:0] LEN_1 = 7'h01;
    localparam logic [6:0] LEN_8 = 7'h08;
    localparam logic [6:0] LEN_64 = 7'h40;
    localparam logic [6:0] LEN_SAMPLE_MAX = 7'h40;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int COL_W = 11;
    localparam int ROW_W = 10;
    localparam logic [10:0] COL_LAST = 11'h4ff;
    localparam logic [9:0] ROW_LAST = 10'h3ff;

    // Configuration carrier
    typedef struct packed {
        logic [3:0] strobe_len;
        logic [3:0] coding;
        logic [5:0] sample_w;
        logic [5:0] reset_w;
    } rtc_cfg_type;

endpackage

// ---- rtc_pulse.sv ----
// Programmable width pulse generator, counted in master clocks
`timescale 1ns/1ns
module rtc_pulse
    import rtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Control
    input wire logic start_i,
    input wire logic row_end_i,
    input wire logic [6:0] len_i,
    // Result
    output logic pulse_o,
    output logic done_o
);

    logic active_r;
    logic full_r;
    logic [6:0] cnt_r;
    logic last_w;

    // Counted pulse ends on its last cycle, full-row pulse on row end
    assign last_w = active_r && (full_r ? row_end_i : (cnt_r == 7'h01));
    assign pulse_o = active_r;
    assign done_o = last_w && !start_i;

    // Start wins over end so back-to-back rows keep their strobe
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            active_r <= 1'b0;
            full_r <= 1'b0;
            cnt_r <= 7'h00;
        end else if (start_i) begin
            active_r <= 1'b1;
            full_r <= (len_i == LEN_FULL_ROW);
            cnt_r <= len_i;
        end else if (active_r) begin
            active_r <= !last_w;
            cnt_r <= cnt_r - 7'h01;
        end
    end

endmodule

// ---- rtc_readout_timing.sv ----
// Readout timing and addressing configuration with strobe generation
`timescale 1ns/1ns
module rtc_readout_timing
    import rtc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port from the serial interface engine
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Frame and row events from the sequencer
    input wire logic frame_start_i,
    input wire logic row_start_i,
    input wire logic row_end_i,
    input wire logic [COL_W-1:0] col_cnt_i,
    input wire logic [ROW_W-1:0] row_cnt_i,
    // Strobes and pulses
    output logic row_valid_strobe_o,
    output logic sof_strobe_o,
    output logic sample_pulse_o,
    output logic reset_pulse_o,
    // Array addresses
    output logic [COL_W-1:0] col_addr_o,
    output logic [ROW_W-1:0] row_addr_o
);

    // ------------------------------------------------------------
    // Register write and read
    // ------------------------------------------------------------
    rtc_cfg_type shadow_r;
    rtc_cfg_type shadow_nxt;
    rtc_cfg_type active_r;
    rtc_cfg_type use_w;
    logic [7:0] rdata_nxt;
    logic wr_len_w, wr_code_w, wr_shs_w, wr_shr_w;

    // Address decode
    assign wr_len_w = reg_wr_i && (reg_addr_i == STROBE_LENGTH_CONTROL_ADDR);
    assign wr_code_w = reg_wr_i &&
        (reg_addr_i == ADDRESS_CODING_DIRECTION_ADDR);
    assign wr_shs_w = reg_wr_i && (reg_addr_i == SAMPLE_PULSE_WIDTH_ADDR);
    assign wr_shr_w = reg_wr_i && (reg_addr_i == RESET_PULSE_WIDTH_ADDR);

    // Only the defined low bits are stored; the rest are dropped
    assign shadow_nxt.strobe_len =
        wr_len_w ? reg_wdata_i[3:0] : shadow_r.strobe_len;
    assign shadow_nxt.coding =
        wr_code_w ? reg_wdata_i[3:0] : shadow_r.coding;
    assign shadow_nxt.sample_w =
        wr_shs_w ? reg_wdata_i[5:0] : shadow_r.sample_w;
    assign shadow_nxt.reset_w =
        wr_shr_w ? reg_wdata_i[5:0] : shadow_r.reset_w;

    // Read mux, upper bits zero, unmapped reads zero
    assign rdata_nxt =
        (reg_addr_i == STROBE_LENGTH_CONTROL_ADDR) ?
            {4'h0, shadow_r.strobe_len} :
        (reg_addr_i == ADDRESS_CODING_DIRECTION_ADDR) ?
            {4'h0, shadow_r.coding} :
        (reg_addr_i == SAMPLE_PULSE_WIDTH_ADDR) ?
            {2'h0, shadow_r.sample_w} :
        (reg_addr_i == RESET_PULSE_WIDTH_ADDR) ?
            {2'h0, shadow_r.reset_w} : 8'h00;

    // New frame sees the freshly loaded settings in its first cycle
    assign use_w = frame_start_i ? shadow_r : active_r;

    // Shadow, live copy and read data
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shadow_r <= {STROBE_LENGTH_RST, ADDRESS_CODING_RST,
                         SAMPLE_PULSE_RST, RESET_PULSE_RST};
            active_r <= {STROBE_LENGTH_RST, ADDRESS_CODING_RST,
                         SAMPLE_PULSE_RST, RESET_PULSE_RST};
            reg_rdata_o <= 8'h00;
        end else begin
            shadow_r <= shadow_nxt;
            active_r <= use_w;
            reg_rdata_o <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Width decode
    // ------------------------------------------------------------
    function automatic logic [6:0] strobe_len(input logic [1:0] code);
        logic [6:0] len;
        len = LEN_FULL_ROW;
        unique case (code)
            WIDTH_CODE_1: len = LEN_1;
            WIDTH_CODE_8: len = LEN_8;
            WIDTH_CODE_64: len = LEN_64;
            WIDTH_CODE_ROW: len = LEN_FULL_ROW;
        endcase
        return len;
    endfunction

    // Zero means the longest pulse, so no pulse can vanish
    function automatic logic [6:0] sample_len(input logic [5:0] w);
        return (w == 6'h00) ? LEN_SAMPLE_MAX : {1'b0, w};
    endfunction

    logic [6:0] rvs_len_w, sof_len_w, shs_len_w, shr_len_w;
    logic shs_done_w;

    assign rvs_len_w = strobe_len(use_w.strobe_len[ROW_VALID_LSB+:2]);
    assign sof_len_w = strobe_len(use_w.strobe_len[SOF_LSB+:2]);
    assign shs_len_w = sample_len(use_w.sample_w);
    assign shr_len_w = sample_len(use_w.reset_w);

    // ------------------------------------------------------------
    // Pulse generators
    // ------------------------------------------------------------
    rtc_pulse u_rvs (
        .clk_i(clk_i), .resetn_i(resetn_i), .start_i(row_start_i),
        .row_end_i(row_end_i), .len_i(rvs_len_w),
        .pulse_o(row_valid_strobe_o), .done_o()
    );
    rtc_pulse u_sof (
        .clk_i(clk_i), .resetn_i(resetn_i), .start_i(frame_start_i),
        .row_end_i(row_end_i), .len_i(sof_len_w),
        .pulse_o(sof_strobe_o), .done_o()
    );
    rtc_pulse u_shs (
        .clk_i(clk_i), .resetn_i(resetn_i), .start_i(row_start_i),
        .row_end_i(row_end_i), .len_i(shs_len_w),
        .pulse_o(sample_pulse_o), .done_o(shs_done_w)
    );
    // Reset sample follows the signal sample, so both fit in one row
    rtc_pulse u_shr (
        .clk_i(clk_i), .resetn_i(resetn_i), .start_i(shs_done_w),
        .row_end_i(row_end_i), .len_i(shr_len_w),
        .pulse_o(reset_pulse_o), .done_o()
    );

    // ------------------------------------------------------------
    // Address direction and coding
    // ------------------------------------------------------------
    logic [COL_W-1:0] col_dir_w, col_nxt;
    logic [ROW_W-1:0] row_dir_w, row_nxt;

    assign col_dir_w = use_w.coding[COL_REV_BIT] ?
                       (COL_LAST - col_cnt_i) : col_cnt_i;
    assign row_dir_w = use_w.coding[ROW_REV_BIT] ?
                       (ROW_LAST - row_cnt_i) : row_cnt_i;
    assign col_nxt = use_w.coding[COL_GRAY_BIT] ?
                     (col_dir_w ^ (col_dir_w >> 1)) : col_dir_w;
    assign row_nxt = use_w.coding[ROW_GRAY_BIT] ?
                     (row_dir_w ^ (row_dir_w >> 1)) : row_dir_w;

    // Registered addresses avoid glitches on the decoder lines
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            col_addr_o <= '0;
            row_addr_o <= '0;
        end else begin
            col_addr_o <= col_nxt;
            row_addr_o <= row_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // A row start on the last strobe cycle may raise it again at once
    AST_RVS_ONE: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        row_start_i && rvs_len_w == LEN_1
        |=> row_valid_strobe_o
        ##1 (!row_valid_strobe_o || $past(row_start_i)))
        else $error("row valid strobe not one clock");
    AST_RVS_EIGHT: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        row_start_i && rvs_len_w == LEN_8 ##1 !row_start_i[*8]
        |=> !row_valid_strobe_o && $past(row_valid_strobe_o, 8))
        else $error("row valid strobe not eight clocks");
    AST_RVS_FULL: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        row_valid_strobe_o && row_end_i && !row_start_i
        && rvs_len_w == LEN_FULL_ROW |=> !row_valid_strobe_o)
        else $error("full row strobe outlives row end");
    AST_SOF_64: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        frame_start_i && sof_len_w == LEN_64 |-> ##64 sof_strobe_o
        ##1 (!sof_strobe_o || $past(frame_start_i)))
        else $error("sof strobe not 64 clocks");
    AST_SOF_FULL: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        sof_strobe_o && row_end_i && !frame_start_i
        && sof_len_w == LEN_FULL_ROW |=> !sof_strobe_o)
        else $error("full row sof outlives row end");
    AST_COL_ADDR: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        !use_w.coding[COL_GRAY_BIT] && use_w.coding[COL_REV_BIT]
        |=> col_addr_o == COL_LAST - $past(col_cnt_i))
        else $error("column reverse address wrong");
    AST_ROW_GRAY: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        use_w.coding[ROW_GRAY_BIT] && !use_w.coding[ROW_REV_BIT]
        |=> row_addr_o == ($past(row_cnt_i) ^ ($past(row_cnt_i) >> 1)))
        else $error("row gray address wrong");
    // Rows are spaced wider than the longest pulse, so no restart here
    AST_SHS_ZERO: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        row_start_i && use_w.sample_w == 6'h00
        |-> ##64 sample_pulse_o ##1 !sample_pulse_o)
        else $error("zero sample width not maximal");
    AST_SHR_AFTER: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        shs_done_w |=> reset_pulse_o && !sample_pulse_o)
        else $error("reset pulse does not follow sample");
    AST_UPPER_ZERO: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        $past(reg_addr_i) == STROBE_LENGTH_CONTROL_ADDR
        |-> reg_rdata_o[7:4] == 4'h0)
        else $error("unused bits read nonzero");
    // Stored low bits come back, the two dropped bits read zero
    AST_SHS_READ: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        $past(wr_shs_w) && reg_addr_i == SAMPLE_PULSE_WIDTH_ADDR
        |=> reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0], 2)})
        else $error("sample width read back wrong");
    AST_FRAME_HOLD: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        !frame_start_i |=> active_r == $past(active_r))
        else $error("setting changed inside frame");

endmodule

// ---- rtc_host.sv ----
// Host model that writes and reads the sensor configuration registers
`timescale 1ns/1ns
module rtc_host (
    // Clock
    input wire logic clk_i,
    // Register port
    input wire logic [7:0] reg_rdata_i,
    output logic reg_wr_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    // Idle bus from time zero
    initial begin
        reg_wr_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // One-cycle strobe; stale data is inverted so nothing leans on it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #5 reg_wr_o = 1'b1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(posedge clk_i);
        #5 reg_wr_o = 1'b0;
        reg_wdata_o = ~d;
    endtask

    // Address is a level; read data trails it by one cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #5 reg_addr_o = a;
        @(posedge clk_i);
        @(posedge clk_i);
        #1 d = reg_rdata_i;
    endtask
endmodule

// ---- rtc_readout_timing_tb_top.sv ----
// Self-checking bench for the readout timing configuration block
`timescale 1ns/1ns
module rtc_readout_timing_tb_top
    import rtc_pkg::*;
    ;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic fs = 1'b0, rs = 1'b0, re = 1'b0;
    logic [10:0] col_cnt = 11'h000;
    logic [9:0] row_cnt = 10'h000;
    logic wr, rv, sof, smp, rsp;
    logic [7:0] addr, wdata, rdata;
    logic [10:0] col_addr;
    logic [9:0] row_addr;
    int n_errors = 0, checked = 0, cyc = 0;
    int cnt[4];

    // 20 MHz master clock
    always #25 clk_i = ~clk_i;

    rtc_host i_host (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_wr_o(wr),
        .reg_addr_o(addr), .reg_wdata_o(wdata));

    rtc_readout_timing i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .frame_start_i(fs), .row_start_i(rs),
        .row_end_i(re), .col_cnt_i(col_cnt), .row_cnt_i(row_cnt),
        .row_valid_strobe_o(rv), .sof_strobe_o(sof), .sample_pulse_o(smp),
        .reset_pulse_o(rsp), .col_addr_o(col_addr), .row_addr_o(row_addr));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic results();
        if (n_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_host.rd(a, d);
        chk($sformatf("reg_%h", a), e, d);
    endtask

    // Frame plus row start, then high cycles of each output over a row
    task automatic run_row(input int e_at);
        cnt = '{4{0}};
        @(posedge clk_i);
        #5 fs = 1'b1;
        rs = 1'b1;
        for (int i = 1; i <= 140; i++) begin
            @(posedge clk_i);
            #5 fs = 1'b0;
            rs = 1'b0;
            re = (i == e_at);
            cnt[0] += (rv === 1'b1);
            cnt[1] += (sof === 1'b1);
            cnt[2] += (smp === 1'b1);
            cnt[3] += (rsp === 1'b1);
        end
    endtask

    // Expected coded addresses: reverse first, then Gray
    function automatic logic [10:0] col_exp(input logic [3:0] c);
        logic [10:0] x;
        x = c[0] ? 11'h4ff - col_cnt : col_cnt;
        return c[2] ? x ^ (x >> 1) : x;
    endfunction

    function automatic logic [9:0] row_exp(input logic [3:0] c);
        logic [9:0] x;
        x = c[1] ? 10'h3ff - row_cnt : row_cnt;
        return c[3] ? x ^ (x >> 1) : x;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_defaults();
        run_row(100);
        chk("row_valid_strobe", 16'd64, cnt[0]);
        chk("sof_strobe", 16'd100, cnt[1]);
        chk("sample_pulse", 16'd10, cnt[2]);
        chk("reset_pulse", 16'd10, cnt[3]);
    endtask

    task automatic t_regs();
        rd_chk(STROBE_LENGTH_CONTROL_ADDR, 8'h0e);
        rd_chk(ADDRESS_CODING_DIRECTION_ADDR, 8'h04);
        rd_chk(SAMPLE_PULSE_WIDTH_ADDR, 8'h0a);
        rd_chk(RESET_PULSE_WIDTH_ADDR, 8'h0a);
        i_host.wr(8'h58, 8'hff);
        rd_chk(8'h58, 8'h00);
        i_host.wr(SAMPLE_PULSE_WIDTH_ADDR, 8'hff);
        rd_chk(SAMPLE_PULSE_WIDTH_ADDR, 8'h3f);
    endtask

    // Every width code on both strobes; full row ends on row end
    task automatic t_strobes();
        int w[4] = '{1, 8, 64, 90};
        for (int c = 0; c < 4; c++) begin
            i_host.wr(STROBE_LENGTH_CONTROL_ADDR, {4'h0, c[1:0], c[1:0]});
            run_row(c == 3 ? 90 : 0);
            chk("row_valid_strobe", w[c], cnt[0]);
            chk("sof_strobe", w[c], cnt[1]);
        end
    endtask

    // Smallest, largest and zero sample widths, reset width 5 or zero, set independently
    task automatic t_pulses();
        logic [5:0] s[3] = '{6'h01, 6'h3f, 6'h00};
        logic [5:0] r[3] = '{6'h05, 6'h00, 6'h00};
        for (int k = 0; k < 3; k++) begin
            i_host.wr(SAMPLE_PULSE_WIDTH_ADDR, {2'h0, s[k]});
            i_host.wr(RESET_PULSE_WIDTH_ADDR, {2'h0, r[k]});
            run_row(0);
            chk("sample_pulse", s[k] == 0 ? 64 : s[k], cnt[2]);
            chk("reset_pulse", r[k] == 0 ? 64 : r[k], cnt[3]);
        end
        chk("pulse_total", 16'd128, cnt[2] + cnt[3]);
    endtask

    // All coding and direction settings; held until the next frame
    task automatic t_addr();
        logic [3:0] p = ADDRESS_CODING_RST;
        for (int c = 0; c < 16; c++) begin
            col_cnt = 11'(c * 77);
            row_cnt = 10'(c * 61 + 3);
            i_host.wr(ADDRESS_CODING_DIRECTION_ADDR, {4'h0, c[3:0]});
            @(posedge clk_i);
            #5 chk("col_addr", col_exp(p), col_addr);
            @(posedge clk_i);
            #5 fs = 1'b1;
            @(posedge clk_i);
            #5 fs = 1'b0;
            @(posedge clk_i);
            #5 chk("col_addr", col_exp(c[3:0]), col_addr);
            chk("row_addr", row_exp(c[3:0]), row_addr);
            p = c[3:0];
        end
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        #5 resetn_i = 1'b1;
        t_defaults();
        t_regs();
        t_strobes();
        t_pulses();
        t_addr();
        results();
    end

    // Hang guard, well above the expected run length
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end
endmodule
